// *** logic/sfm_pkg.sv ***
// Package: register map, field positions and reset values of the supply fault monitor
package sfm_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_GEN_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_FAULT      = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
   localparam logic [7:0] ADDR_CHAN_CTRL  = 8'h14;
   // General configuration fields
   localparam int CFG_OV_DISABLE  = 0;
   localparam int CFG_RETRY_EN0   = 1;
   localparam int CFG_RETRY_EN1   = 2;
   // Status fields
   localparam int ST_OV      = 0;
   localparam int ST_UV      = 1;
   localparam int ST_POR     = 2;
   localparam int ST_FSAFE   = 3;
   localparam int ST_CH_ON0  = 4;
   localparam int ST_OV_LIVE = 6;
   localparam int ST_UV_LIVE = 7;
   // Fault register fields, per channel ch: base + 4*ch, retry bits base + ch
   localparam int FL_OT   = 0;
   localparam int FL_OC   = 1;
   localparam int FL_SC   = 2;
   localparam int FL_OL   = 3;
   localparam int FL_RTRY = 8;
   // Channel control fields
   localparam int CC_ON0      = 0;
   localparam int CC_DELATCH0 = 2;
   // Interrupt events
   localparam int IRQ_OV  = 0;
   localparam int IRQ_UV  = 1;
   localparam int IRQ_GND = 2;
   localparam int IRQ_OT  = 3;
   localparam int NIRQ    = 4;
   // Reset values
   localparam logic [2:0] GEN_CONFIG_RST = 3'h0;
   localparam logic [3:0] IRQ_MASK_RST   = 4'h0;
   // Number of analog comparator flags in the main synchronizer bank
   localparam int NCMP = 13;
   localparam int SYNC_STAGES = 2;
endpackage

// *** logic/sfm_sync.sv ***
// Two-flop synchronizer bank for analog comparator outputs
`timescale 1ns/100ps
`default_nettype none
module sfm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** logic/sfm_top.sv ***
// Supply fault monitor: fault supervision, channel gating, flags and APB registers
`timescale 1ns/100ps
`default_nettype none
module sfm_top (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog comparators, asynchronous
   input  wire logic        ov_cmp,
   input  wire logic        ov_hys_cmp,
   input  wire logic        uv_cmp,
   input  wire logic        below_6v_cmp,
   input  wire logic        vdd_fail_cmp,
   input  wire logic        sys_gnd_loss_cmp,
   input  wire logic        gnd_shift_cmp,
   input  wire logic [1:0]  ot_cmp,
   input  wire logic [1:0]  oc_cmp,
   input  wire logic [1:0]  sc_cmp,
   // Per-channel load ground loss, comparator
   input  wire logic [1:0]  load_gnd_loss_cmp,
   // Channel outputs
   output logic      [1:0]  channel_on,
   output logic      [1:0]  fast_off,
   output logic      [1:0]  retry_start,
   output logic             fault_status_n,
   output logic             fail_safe,
   output logic             irq
);
   logic [12:0] cmp_s;
   logic        ov_s, ov_hys_s, uv_s, lo6_s, vddf_s, sgl_s, gsh_s;
   logic [1:0]  ot_s, oc_s, sc_s, lgl_s;

   sfm_sync #(.W(sfm_pkg::NCMP)) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in ({ov_cmp, ov_hys_cmp, uv_cmp, below_6v_cmp, vdd_fail_cmp, sys_gnd_loss_cmp,
                  gnd_shift_cmp, ot_cmp, oc_cmp, sc_cmp}),
      .sync_out (cmp_s)
   );
   assign {ov_s, ov_hys_s, uv_s, lo6_s, vddf_s, sgl_s, gsh_s, ot_s, oc_s, sc_s} = cmp_s;

   sfm_sync #(.W(2)) u_sync_lgl (
      .clock    (clock),
      .rst      (rst),
      .async_in (load_gnd_loss_cmp),
      .sync_out (lgl_s)
   );

   // Register state
   logic [2:0]  cfg_q;
   logic [1:0]  req_q;
   logic [3:0]  irq_st_q, irq_mask_q;
   logic        ov_flag_q, uv_flag_q, por_q;
   logic [1:0]  ot_flag_q, oc_flag_q, sc_flag_q, ol_flag_q;
   logic        ov_latch_q, uv_prev_q, uv_req_q;
   logic [1:0]  delatch_q, uv_lock_q;
   logic        supply_reset;

   // APB decode; a ground shift blocks all serial access
   logic acc, wr, rd, rd_status, rd_fault;
   assign acc       = psel & penable & pready;
   assign wr        = acc & pwrite & ~gsh_s;
   assign rd        = acc & ~pwrite & ~gsh_s;
   assign rd_status = rd & (paddr == sfm_pkg::ADDR_STATUS);
   assign rd_fault  = rd & (paddr == sfm_pkg::ADDR_FAULT);

   // Logic supply loss or both supplies below reset wipe settings and the OV, UV and fault flags; interrupt status and POR are kept
   assign supply_reset = vddf_s | (lo6_s & vddf_s);

   // One wait-free access phase: pready follows every setup cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   logic ovd;
   assign ovd = cfg_q[sfm_pkg::CFG_OV_DISABLE];

   // Configuration and channel requests; held through extended range
   // A low main supply alone is a plain undervoltage and keeps these settings
   always_ff @(posedge clock) begin
      if (rst || supply_reset) begin
         cfg_q      <= sfm_pkg::GEN_CONFIG_RST;
         req_q      <= 2'h0;
         irq_mask_q <= sfm_pkg::IRQ_MASK_RST;
      end else if (wr) begin
         if (paddr == sfm_pkg::ADDR_GEN_CONFIG) begin
            cfg_q <= pwdata[2:0];
         end
         if (paddr == sfm_pkg::ADDR_IRQ_MASK) begin
            irq_mask_q <= pwdata[3:0];
         end
         if (paddr == sfm_pkg::ADDR_CHAN_CTRL) begin
            req_q <= pwdata[1:0];
         end
      end
   end

   // Delatch pulses remembered until the channel actually turns on
   logic dl_wr;
   assign dl_wr = wr & (paddr == sfm_pkg::ADDR_CHAN_CTRL);
   always_ff @(posedge clock) begin
      if (rst || supply_reset) begin
         delatch_q <= 2'h3;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (dl_wr && pwdata[sfm_pkg::CC_DELATCH0 + c]) begin
               delatch_q[c] <= 1'b1;
            end else if (channel_on[c]) begin
               delatch_q[c] <= 1'b0;
            end
         end
      end
   end

   // Overvoltage latch released only by the hysteretic comparator
   always_ff @(posedge clock) begin
      if (rst || supply_reset) begin
         ov_latch_q <= 1'b0;
      end else if (ov_s && !ovd) begin
         ov_latch_q <= 1'b1;
      end else if (!ov_hys_s) begin
         ov_latch_q <= 1'b0;
      end
   end

   // Overvoltage flag: set wins over the clearing read
   always_ff @(posedge clock) begin
      if (rst || supply_reset) begin
         ov_flag_q <= 1'b0;
      end else if (ov_s) begin
         ov_flag_q <= 1'b1;
      end else if (rd_status && !ov_latch_q && !ov_hys_s) begin
         ov_flag_q <= 1'b0;
      end
   end

   // Undervoltage lockout per channel and shared flag
   always_ff @(posedge clock) begin
      if (rst || supply_reset) begin
         uv_prev_q <= 1'b0;
         uv_req_q  <= 1'b0;
         uv_lock_q <= 2'h0;
      end else begin
         uv_prev_q <= uv_s;
         if (uv_s && (req_q != 2'h0)) begin
            uv_req_q <= 1'b1;
         end else if (rd_status && !uv_s) begin
            uv_req_q <= 1'b0;
         end
         for (int c = 0; c < 2; c++) begin
            if (uv_s && req_q[c]) begin
               uv_lock_q[c] <= 1'b1;
            end else if (delatch_q[c] || !req_q[c]) begin
               uv_lock_q[c] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst || supply_reset) begin
         uv_flag_q <= 1'b0;
      end else if (uv_s) begin
         uv_flag_q <= 1'b1;
      end else if (uv_req_q) begin
         if (rd_status) begin
            uv_flag_q <= 1'b0;
         end
      end else if (channel_on != 2'h0) begin
         uv_flag_q <= 1'b0;
      end
   end

   // Per-channel latchable faults and open load
   logic [1:0] fault_clr;
   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         assign fault_clr[c] = rd_fault & delatch_q[c];
         always_ff @(posedge clock) begin
            if (rst || supply_reset) begin
               ot_flag_q[c] <= 1'b0;
               oc_flag_q[c] <= 1'b0;
               sc_flag_q[c] <= 1'b0;
               ol_flag_q[c] <= 1'b0;
            end else begin
               // Overtemp reaches the register only with supply above UV
               if (ot_s[c] && !uv_s) begin
                  ot_flag_q[c] <= 1'b1;
               end else if (fault_clr[c] && !ot_s[c]) begin
                  ot_flag_q[c] <= 1'b0;
               end
               if (oc_s[c] && !lo6_s) begin
                  oc_flag_q[c] <= 1'b1;
               end else if (fault_clr[c]) begin
                  oc_flag_q[c] <= 1'b0;
               end
               if (sc_s[c] && !lo6_s) begin
                  sc_flag_q[c] <= 1'b1;
               end else if (fault_clr[c]) begin
                  sc_flag_q[c] <= 1'b0;
               end
               if (lgl_s[c]) begin
                  ol_flag_q[c] <= 1'b1;
               end else if (rd_fault) begin
                  ol_flag_q[c] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Channel gating; load ground loss deliberately not a term here
   logic [1:0] retry_cond, latch_off, kill, on_d;
   logic       ov_kill;
   assign ov_kill    = (ov_s & ~ovd) | ov_latch_q;
   assign retry_cond = oc_flag_q | sc_flag_q | ot_flag_q | {2{uv_flag_q}};
   assign latch_off  = oc_flag_q | sc_flag_q | (ot_flag_q & ~delatch_q);
   // Below 6 V only the overtemperature sensor and the undervoltage lockout still act
   assign kill = {2{lo6_s ? 1'b0 : (ov_kill | uv_s | sgl_s)}} | ot_s
                 | {2{uv_s}} | uv_lock_q | (lo6_s ? 2'h0 : (oc_s | sc_s));
   assign on_d = req_q & ~kill & ~latch_off;

   // Retry start is one pulse on the falling edge of the live undervoltage
   always_ff @(posedge clock) begin
      if (rst) begin
         channel_on  <= 2'h0;
         fast_off    <= 2'h0;
         retry_start <= 2'h0;
      end else begin
         channel_on  <= on_d;
         fast_off    <= {2{uv_s}} | oc_s | sc_s | ot_s;
         retry_start <= {cfg_q[sfm_pkg::CFG_RETRY_EN1], cfg_q[sfm_pkg::CFG_RETRY_EN0]}
                        & {2{uv_prev_q & ~uv_s}} & retry_cond;
      end
   end

   // Fault pin, fail-safe and interrupt
   logic [3:0] irq_ev;
   assign irq_ev = {|ot_s, sgl_s, uv_s, ov_s};
   always_ff @(posedge clock) begin
      if (rst) begin
         fault_status_n <= 1'b1;
         fail_safe      <= 1'b0;
         irq_st_q       <= 4'h0;
         irq            <= 1'b0;
      end else begin
         fault_status_n <= ~(ov_kill | uv_s | (|(oc_flag_q | sc_flag_q)) | (|ot_s));
         fail_safe      <= gsh_s;
         for (int i = 0; i < sfm_pkg::NIRQ; i++) begin
            if (irq_ev[i]) begin
               irq_st_q[i] <= 1'b1;
            end else if (wr && paddr == sfm_pkg::ADDR_IRQ_STATUS && pwdata[i]) begin
               irq_st_q[i] <= 1'b0;
            end
         end
         irq <= |(irq_st_q & irq_mask_q);
      end
   end

   // Read mux
   logic [31:0] rd_d;
   logic        mapped;
   always_comb begin
      rd_d   = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         sfm_pkg::ADDR_GEN_CONFIG: rd_d[2:0] = cfg_q;
         sfm_pkg::ADDR_STATUS: begin
            rd_d[sfm_pkg::ST_OV]      = ov_flag_q;
            rd_d[sfm_pkg::ST_UV]      = uv_flag_q;
            rd_d[sfm_pkg::ST_POR]     = por_q;
            rd_d[sfm_pkg::ST_FSAFE]   = fail_safe;
            rd_d[sfm_pkg::ST_CH_ON0 +: 2] = channel_on;
            rd_d[sfm_pkg::ST_OV_LIVE] = ov_s;
            rd_d[sfm_pkg::ST_UV_LIVE] = uv_s;
         end
         sfm_pkg::ADDR_FAULT: begin
            for (int c = 0; c < 2; c++) begin
               rd_d[4*c + sfm_pkg::FL_OT] = ot_flag_q[c];
               rd_d[4*c + sfm_pkg::FL_OC] = oc_flag_q[c];
               rd_d[4*c + sfm_pkg::FL_SC] = sc_flag_q[c];
               rd_d[4*c + sfm_pkg::FL_OL] = ol_flag_q[c];
               rd_d[sfm_pkg::FL_RTRY + c] = retry_cond[c];
            end
         end
         sfm_pkg::ADDR_IRQ_STATUS: rd_d[3:0] = irq_st_q;
         sfm_pkg::ADDR_IRQ_MASK:   rd_d[3:0] = irq_mask_q;
         sfm_pkg::ADDR_CHAN_CTRL:  rd_d[1:0] = req_q;
         default: mapped = 1'b0;
      endcase
   end

   // Read data is taken in the setup cycle so that it stands in the access cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         por_q   <= 1'b1;
      end else begin
         prdata  <= (psel & ~penable & ~pwrite & ~gsh_s) ? rd_d : 32'h0000_0000;
         pslverr <= psel & ~penable & (~mapped | gsh_s);
         if (rd_status) begin
            por_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/sfm_supply_model.sv ***
// Supply front end model: comparator levels for one supply condition
`timescale 1ns/100ps
`default_nettype none
module sfm_supply_model (
   // Condition chosen by the bench
   input  wire logic [2:0] supply_state,
   // Comparator levels
   output logic            ov_cmp,
   output logic            ov_hys_cmp,
   output logic            uv_cmp,
   output logic            below_6v_cmp
);
   // 0 normal, 1 over, 2 inside hysteresis band, 3 under, 4 below 6 V
   always_comb begin
      ov_cmp       = supply_state == 3'h1;
      ov_hys_cmp   = supply_state inside {3'h1, 3'h2};
      uv_cmp       = supply_state inside {3'h3, 3'h4};
      below_6v_cmp = supply_state == 3'h4;
   end
endmodule
`default_nettype wire

// *** testbench/sfm_chk.sv ***
// Checker: port assertions of the supply fault monitor
`timescale 1ns/100ps
`default_nettype none
module sfm_chk (
   // Clock, reset and bus
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Comparators and outputs
   input wire logic        ov_cmp,
   input wire logic        uv_cmp,
   input wire logic        vdd_fail_cmp,
   input wire logic        sys_gnd_loss_cmp,
   input wire logic        gnd_shift_cmp,
   input wire logic [1:0]  sc_cmp,
   input wire logic [1:0]  channel_on,
   input wire logic [1:0]  fast_off,
   input wire logic        fault_status_n,
   input wire logic        fail_safe
);
   logic [2:0] up_q;
   logic       overvoltage_disable_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Keeps checks clear of synchronizer contents loaded by a reset
   always_ff @(posedge clock) begin
      if (rst) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
   end
   always_ff @(posedge clock) begin
      if (rst || vdd_fail_cmp) overvoltage_disable_q <= 1'h0;
      else if (psel && penable && pready && pwrite && !pslverr
               && paddr == sfm_pkg::ADDR_GEN_CONFIG)
         overvoltage_disable_q <= pwdata[sfm_pkg::CFG_OV_DISABLE];
   end
   sequence s_ov_held;
      (ov_cmp && !overvoltage_disable_q && up_q == 3'h7)[*4];
   endsequence
   sequence s_shift_held;
      (gnd_shift_cmp && up_q == 3'h7)[*5];
   endsequence
   AST_OV_KILL: assert property (s_ov_held |-> channel_on == 2'h0 && !fault_status_n)
      else $error("channel on or pin high during overvoltage");
   AST_UV_KILL: assert property ((uv_cmp && up_q == 3'h7)[*4] |->
      channel_on == 2'h0 && !fault_status_n) else $error("channel on during undervoltage");
   AST_FAST_OFF: assert property ((sc_cmp[0] && up_q == 3'h7)[*4] |-> fast_off[0])
      else $error("no fast turn-off on short circuit");
   AST_SYS_GND: assert property ((sys_gnd_loss_cmp && up_q == 3'h7)[*4] |-> !channel_on)
      else $error("channel on after system ground loss");
   AST_FAIL_SAFE: assert property ((gnd_shift_cmp && up_q == 3'h7)[*4] |-> fail_safe)
      else $error("fail-safe not entered on ground shift");
   AST_SHIFT_ERR: assert property (s_shift_held ##0 psel && penable |-> pready && pslverr)
      else $error("bus access accepted during ground shift");
   AST_SYNC_DELAY: assert property ($rose(gnd_shift_cmp) && !fail_safe && up_q == 3'h7
      |-> ##1 !fail_safe ##1 !fail_safe) else $error("comparator used before two stages");
   AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("access phase not one cycle");
endmodule
bind sfm_top sfm_chk sfm_chk_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .ov_cmp(ov_cmp), .uv_cmp(uv_cmp), .vdd_fail_cmp(vdd_fail_cmp),
   .sys_gnd_loss_cmp(sys_gnd_loss_cmp), .gnd_shift_cmp(gnd_shift_cmp), .sc_cmp(sc_cmp),
   .channel_on(channel_on), .fast_off(fast_off), .fault_status_n(fault_status_n),
   .fail_safe(fail_safe));
`default_nettype wire

// *** testbench/tb_supply_fault_monitor.sv ***
// Testbench: supply fault monitor scenarios over APB and comparator levels
`timescale 1ns/100ps
`default_nettype none
module tb_supply_fault_monitor;
   localparam logic [7:0]  A_CFG = sfm_pkg::ADDR_GEN_CONFIG;
   localparam logic [7:0]  A_ST  = sfm_pkg::ADDR_STATUS;
   localparam logic [7:0]  A_CC  = sfm_pkg::ADDR_CHAN_CTRL;
   localparam logic [31:0] M_OV  = 32'h1 << sfm_pkg::ST_OV;
   localparam logic [31:0] M_UV  = 32'h1 << sfm_pkg::ST_UV;
   localparam logic [31:0] DL0   = 32'h1 << sfm_pkg::CC_DELATCH0;
   localparam logic [31:0] M_OL  = 32'h1 << sfm_pkg::FL_OL;
   localparam logic [31:0] I_OV  = 32'h1 << sfm_pkg::IRQ_OV;
   localparam logic [31:0] M_OT  = 32'h1 << sfm_pkg::FL_OT;
   localparam logic [31:0] R_MSK = 32'h3 << sfm_pkg::FL_RTRY;
   logic        clock = 1'h0, rst = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic [2:0]  sup = 3'h0;
   logic        ov, ovh, uv, b6;
   logic        sysg = 1'h0, gsh = 1'h0;
   logic [1:0]  sc = 2'h0, lgl = 2'h0;
   logic [1:0]  ot = 2'h0, oc = 2'h0;
   logic        vddf = 1'h0;
   logic [1:0]  chon, foff, rtry;
   logic        fsn, fsafe, irq;
   int          num_errors = 0;
   int          n_tests = 0;

   always #5 clock = ~clock;

   sfm_supply_model sfm_supply_model_i (.supply_state(sup), .ov_cmp(ov), .ov_hys_cmp(ovh),
      .uv_cmp(uv), .below_6v_cmp(b6));
   sfm_top sfm_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ov_cmp(ov), .ov_hys_cmp(ovh), .uv_cmp(uv), .below_6v_cmp(b6),
      .vdd_fail_cmp(vddf), .sys_gnd_loss_cmp(sysg), .gnd_shift_cmp(gsh), .ot_cmp(ot),
      .oc_cmp(oc), .sc_cmp(sc), .load_gnd_loss_cmp(lgl), .channel_on(chon),
      .fast_off(foff), .retry_start(rtry), .fault_status_n(fsn), .fail_safe(fsafe),
      .irq(irq));

   task automatic summarize;
      $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Holds the request until pready is seen; the bound only guards a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20) num_errors++;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, a, d, r, e);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      chk(r & m, x);
   endtask

   task automatic t_ov;
      wr(A_CC, 32'h1);
      sup <= 3'h1;
      wt(5);
      chk(32'({chon, fsn}), 32'h0);
      sup <= 3'h2;
      wt(5);
      chk(32'(chon), 32'h0);
      rdchk(A_ST, M_OV, M_OV);
      chk(32'(irq), 32'h0);
      wr(sfm_pkg::ADDR_IRQ_MASK, I_OV);
      wt(1);
      chk(32'(irq), 32'h1);
      wr(sfm_pkg::ADDR_IRQ_STATUS, I_OV);
      wt(1);
      chk(32'(irq), 32'h0);
      sup <= 3'h0;
      wt(5);
      chk(32'(chon), 32'h1);
      rdchk(A_ST, M_OV, M_OV);
      rdchk(A_ST, M_OV, 32'h0);
   endtask
   task automatic t_ovdis;
      wr(A_CFG, 32'h1 << sfm_pkg::CFG_OV_DISABLE);
      sup <= 3'h1;
      wt(5);
      chk(32'({chon, fsn}), 32'h3);
      rdchk(A_ST, M_OV, M_OV);
      sup <= 3'h0;
      wt(5);
      rdchk(A_ST, M_OV, M_OV);
      wr(A_CFG, 32'h0);
   endtask
   task automatic t_uv_req;
      int n;
      sup <= 3'h3;
      wt(5);
      chk(32'({chon, fsn, foff}), 32'h3);
      sup <= 3'h0;
      wt(5);
      chk(32'(chon), 32'h0);
      wr(A_CC, 32'h1 | DL0);
      wt(3);
      chk(32'(chon), 32'h1);
      rdchk(A_ST, M_UV, M_UV);
      rdchk(A_ST, M_UV, 32'h0);
      wr(A_CFG, 32'h1 << sfm_pkg::CFG_RETRY_EN0);
      sup <= 3'h3;
      wt(5);
      sup <= 3'h0;
      n = 0;
      while (rtry[0] !== 1'h1 && n < 10) begin
         @(posedge clock);
         n++;
      end
      chk(32'(n < 10), 32'h1);
      wr(A_CFG, 32'h0);
      wr(A_CC, DL0);
      rdchk(A_ST, M_UV, M_UV);
   endtask
   task automatic t_uv_idle;
      sup <= 3'h3;
      wt(5);
      sup <= 3'h0;
      wt(5);
      chk(32'(fsn), 32'h1);
      rdchk(A_ST, M_UV, M_UV);
      rdchk(A_ST, M_UV, M_UV);
      wr(A_CC, 32'h1);
      wt(3);
      rdchk(A_ST, M_UV, 32'h0);
   endtask
   task automatic t_gnd;
      logic [31:0] r;
      logic        e;
      wr(A_CC, 32'h3);
      lgl <= 2'h1;
      wt(5);
      chk(32'(chon), 32'h3);
      rdchk(sfm_pkg::ADDR_FAULT, M_OL, M_OL);
      lgl <= 2'h0;
      sc <= 2'h1;
      wt(5);
      chk(32'(foff[0]), 32'h1);
      sc <= 2'h0;
      sysg <= 1'h1;
      wt(5);
      chk(32'(chon), 32'h0);
      sysg <= 1'h0;
      gsh <= 1'h1;
      wt(5);
      chk(32'(fsafe), 32'h1);
      apb(1'h0, A_ST, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      gsh <= 1'h0;
      wt(5);
      apb(1'h0, 8'h3C, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
   endtask
   task automatic t_supply;
      rdchk(sfm_pkg::ADDR_FAULT, R_MSK, 32'h1 << sfm_pkg::FL_RTRY);
      vddf <= 1'h1;
      wt(5);
      vddf <= 1'h0;
      wt(5);
      rdchk(sfm_pkg::ADDR_FAULT, 32'hFFFF, 32'h0);
      rdchk(A_CC, 32'h3, 32'h0);
      oc <= 2'h2;
      wt(5);
      oc <= 2'h0;
      wt(5);
      rdchk(sfm_pkg::ADDR_FAULT, R_MSK, 32'h2 << sfm_pkg::FL_RTRY);
      wr(A_CC, 32'h1);
      sup <= 3'h4;
      ot <= 2'h1;
      wt(5);
      rdchk(sfm_pkg::ADDR_FAULT, M_OT, 32'h0);
      sup <= 3'h0;
      wt(5);
      rdchk(sfm_pkg::ADDR_FAULT, M_OT, M_OT);
      ot <= 2'h0;
   endtask

   initial begin
      #100000;
      num_errors++;
      summarize();
   end
   initial begin
      wt(10);
      rst <= 1'h0;
      @(posedge clock);
      rdchk(A_ST, 32'hFF, 32'h1 << sfm_pkg::ST_POR);
      chk(32'({chon, fsn, irq}), 32'h2);
      t_ov();
      t_ovdis();
      t_uv_req();
      t_uv_idle();
      t_gnd();
      t_supply();
      summarize();
   end
endmodule
`default_nettype wire
